// ---- logic/crtc_vert_timing.sv ----
// Function
// - Protect bit set blocks writes to controller registers 00 to 07.
// - Overflow bit 4 (line compare) stays writable despite protection.
// - Vertical interrupt enable bit is stored and read back, no effect.
// - No vertical interrupt output; interrupt clear bit is storage only.
// - Sync end field holds low 4 bits of sync start plus length.
// - Display end is 10 bits; overflow bits 6 and 1 on top.
// - Display end names last active line; active lines start at zero.
// - Row offset counts words or doublewords per sequencer clocking setting.
// - Doubleword bit and byte/word bit select word, byte or doubleword addressing.
// - Quad_char_increment with double_char_increment set increment interval of 1, 2 or 4.
// - Underline drawn in text mode on character row given by field.
// - Blank start is 10 bits; max-scan bit 5 then overflow bit 3.
// - Blank end holds low 8 bits of blank start plus length.
// - Sync start is 10 bits; overflow bits 7 and 2 on top.
`timescale 1ns/1ps
module crtc_vert_timing (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Indexed I/O port
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_color_sel,
  output logic [7:0] io_rdata,
  output logic io_rd_hit,
  // Controller context
  input wire logic [9:0] scan_line,
  input wire logic line_start,
  input wire logic [4:0] row_scan,
  input wire logic char_tick,
  input wire logic text_mode,
  input wire logic seq_dword_offset,
  // Timing and addressing outputs
  output logic vsync_out,
  output logic vblank_out,
  output logic vdisp_active,
  output logic underline_hit,
  output logic addr_inc,
  output crtc_vert_pkg::addr_mode_t addr_mode,
  output logic [9:0] row_stride_bytes,
  output logic [9:0] vdisp_end_line,
  output logic [9:0] vsync_start_line,
  output logic [9:0] vblank_start_line
);
  import crtc_vert_pkg::*;

  // Register storage
  logic [7:0] index_q;
  logic [7:0] overflow_q;
  logic [7:0] max_scan_q;
  logic [7:0] vsync_start_q;
  logic [7:0] vsync_end_q;
  logic [7:0] vdisp_end_q;
  logic [7:0] row_offset_q;
  logic [7:0] underline_q;
  logic [7:0] vblank_start_q;
  logic [7:0] vblank_end_q;
  logic [7:0] mode_ctrl_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rd_hit_q;
  logic rd_hit_d;

  // Timing state
  logic vsync_q;
  logic vsync_d;
  logic vblank_q;
  logic vblank_d;
  logic vdisp_q;
  logic vdisp_d;
  logic underline_hit_q;
  logic underline_d;
  logic [9:0] stride_q;
  logic [9:0] stride_d;

  // Port decode
  wire index_port;
  wire data_port;
  wire data_wr;
  wire data_rd;
  wire protect_on;
  wire prot_block;

  // Mono and colour aliases of one port; the select picks which one answers
  function automatic logic port_hit(input logic [15:0] addr, input logic color, input logic [15:0] mono_port,
                                    input logic [15:0] color_port);
    port_hit = color ? (addr == color_port) : (addr == mono_port);
  endfunction : port_hit

  assign index_port = port_hit(io_addr, io_color_sel, IO_INDEX_MONO, IO_INDEX_COLOR);
  assign data_port = port_hit(io_addr, io_color_sel, IO_DATA_MONO, IO_DATA_COLOR);
  assign data_wr = io_wr && data_port;
  assign data_rd = io_rd && data_port;
  assign protect_on = vsync_end_q[VSE_PROTECT_BIT];
  // Of the protected range only the overflow register lives in this block
  assign prot_block = protect_on && (index_q <= IDX_PROTECT_LAST);

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] mask);
    merge = (old & ~mask) | (wr & mask);
  endfunction : merge

  // Per-register write strobes
  wire wr_overflow;
  wire wr_max_scan;
  wire wr_vsync_start;
  wire wr_vsync_end;
  wire wr_vdisp_end;
  wire wr_row_offset;
  wire wr_underline;
  wire wr_vblank_start;
  wire wr_vblank_end;
  wire wr_mode_ctrl;
  wire [7:0] overflow_mask;

  assign wr_overflow = data_wr && (index_q == IDX_OVERFLOW);
  assign wr_max_scan = data_wr && (index_q == IDX_MAX_SCAN);
  assign wr_vsync_start = data_wr && (index_q == IDX_VSYNC_START);
  assign wr_vsync_end = data_wr && (index_q == IDX_VSYNC_END);
  assign wr_vdisp_end = data_wr && (index_q == IDX_VDISP_END);
  assign wr_row_offset = data_wr && (index_q == IDX_ROW_OFFSET);
  assign wr_underline = data_wr && (index_q == IDX_UNDERLINE);
  assign wr_vblank_start = data_wr && (index_q == IDX_VBLANK_START);
  assign wr_vblank_end = data_wr && (index_q == IDX_VBLANK_END);
  assign wr_mode_ctrl = data_wr && (index_q == IDX_MODE_CTRL);
  // Protection leaves only the line-compare bit open
  assign overflow_mask = prot_block ? OVF_UNPROT_MASK : 8'hFF;

  // Read-back multiplexer
  always_comb
  begin
    rd_hit_d = 1'b1;
    rdata_d = 8'h00;
    if (io_rd && index_port)
    begin
      rdata_d = index_q;
    end
    else if (data_rd)
    begin
      case (index_q)
        IDX_OVERFLOW: rdata_d = overflow_q;
        IDX_MAX_SCAN: rdata_d = max_scan_q;
        IDX_VSYNC_START: rdata_d = vsync_start_q;
        IDX_VSYNC_END: rdata_d = vsync_end_q & VSE_WMASK;
        IDX_VDISP_END: rdata_d = vdisp_end_q;
        IDX_ROW_OFFSET: rdata_d = row_offset_q;
        IDX_UNDERLINE: rdata_d = underline_q & UL_WMASK;
        IDX_VBLANK_START: rdata_d = vblank_start_q;
        IDX_VBLANK_END: rdata_d = vblank_end_q;
        IDX_MODE_CTRL: rdata_d = mode_ctrl_q & MC_WMASK;
        default: rd_hit_d = 1'b0;
      endcase
    end
    else
    begin
      rd_hit_d = 1'b0;
    end
  end

  assign io_rdata = rdata_q;
  assign io_rd_hit = rd_hit_q;

  // Index and read-back registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      index_q <= REG_RESET;
      rdata_q <= REG_RESET;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      if (io_wr && index_port)
      begin
        index_q <= io_wdata;
      end
      rdata_q <= rdata_d;
      rd_hit_q <= rd_hit_d;
    end
  end

  // Context registers shared with the rest of the controller
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      overflow_q <= REG_RESET;
      max_scan_q <= REG_RESET;
      vsync_start_q <= REG_RESET;
      mode_ctrl_q <= REG_RESET;
    end
    else
    begin
      if (wr_overflow)
      begin
        overflow_q <= merge(overflow_q, io_wdata, overflow_mask);
      end
      if (wr_max_scan)
      begin
        max_scan_q <= io_wdata;
      end
      if (wr_vsync_start)
      begin
        vsync_start_q <= io_wdata;
      end
      if (wr_mode_ctrl)
      begin
        mode_ctrl_q <= io_wdata & MC_WMASK;
      end
    end
  end

  // Vertical timing registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      vsync_end_q <= REG_RESET;
      vdisp_end_q <= REG_RESET;
      row_offset_q <= REG_RESET;
      underline_q <= REG_RESET;
      vblank_start_q <= REG_RESET;
      vblank_end_q <= REG_RESET;
    end
    else
    begin
      if (wr_vsync_end)
      begin
        // Interrupt enable and clear bits are kept but drive nothing
        vsync_end_q <= io_wdata & VSE_WMASK;
      end
      if (wr_vdisp_end)
      begin
        vdisp_end_q <= io_wdata;
      end
      if (wr_row_offset)
      begin
        row_offset_q <= io_wdata;
      end
      if (wr_underline)
      begin
        underline_q <= io_wdata & UL_WMASK;
      end
      if (wr_vblank_start)
      begin
        vblank_start_q <= io_wdata;
      end
      if (wr_vblank_end)
      begin
        vblank_end_q <= io_wdata;
      end
    end
  end

  // Ten-bit line values
  wire [9:0] vdisp_end10;
  wire [9:0] vsync_start10;
  wire [9:0] vblank_start10;
  wire [3:0] vsync_end4;
  wire timing_run;

  assign vdisp_end10 = join10(overflow_q[OVF_VDISP_B9], overflow_q[OVF_VDISP_B8], vdisp_end_q);
  assign vsync_start10 = join10(overflow_q[OVF_VSYNC_B9], overflow_q[OVF_VSYNC_B8], vsync_start_q);
  assign vblank_start10 = join10(max_scan_q[MSL_VBLANK_B9], overflow_q[OVF_VBLANK_B8], vblank_start_q);
  assign vsync_end4 = vsync_end_q[VSE_END_MSB:0];
  assign timing_run = mode_ctrl_q[MC_RUN_BIT];
  assign vdisp_end_line = vdisp_end10;
  assign vsync_start_line = vsync_start10;
  assign vblank_start_line = vblank_start10;

  // Line event decode
  wire sync_begin;
  wire sync_finish;
  wire blank_begin;
  wire blank_finish;

  assign sync_begin = line_start && (scan_line == vsync_start10);
  assign sync_finish = line_start && (scan_line[3:0] == vsync_end4);
  assign blank_begin = line_start && (scan_line == vblank_start10);
  assign blank_finish = line_start && (scan_line[7:0] == vblank_end_q);

  // Controller reset bit low holds sync inactive; blanking keeps running
  // Start wins when both land on the same line
  assign vsync_d = !timing_run ? 1'b0 : (sync_begin ? 1'b1 : (sync_finish ? 1'b0 : vsync_q));
  assign vblank_d = blank_begin ? 1'b1 : (blank_finish ? 1'b0 : vblank_q);
  // Active from line zero through the programmed last line
  assign vdisp_d = line_start ? (scan_line <= vdisp_end10) : vdisp_q;
  assign underline_d = text_mode && (row_scan == underline_q[UL_LOC_MSB:0]);

  // Stride in bytes: words shift by one, doublewords by two
  assign stride_d = seq_dword_offset ? {row_offset_q, 2'b00} : {1'b0, row_offset_q, 1'b0};

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      vsync_q <= 1'b0;
      vblank_q <= 1'b0;
      vdisp_q <= 1'b0;
      underline_hit_q <= 1'b0;
      stride_q <= 10'h000;
    end
    else
    begin
      vsync_q <= vsync_d;
      vblank_q <= vblank_d;
      vdisp_q <= vdisp_d;
      underline_hit_q <= underline_d;
      stride_q <= stride_d;
    end
  end

  assign vsync_out = vsync_q;
  assign vblank_out = vblank_q;
  assign vdisp_active = vdisp_q;
  assign underline_hit = underline_hit_q;
  assign row_stride_bytes = stride_q;

  // Address mode and increment pacing
  addr_step_if step_bus ();

  assign step_bus.dword_sel = underline_q[UL_DWORD_BIT];
  assign step_bus.byte_sel = mode_ctrl_q[MC_BYTE_BIT];
  assign step_bus.quad_char_increment = underline_q[UL_QUAD_BIT];
  assign step_bus.double_char_increment = mode_ctrl_q[MC_DOUBLE_BIT];
  assign step_bus.char_tick = char_tick;
  assign addr_inc = step_bus.inc_pulse;
  assign addr_mode = step_bus.mode;

  addr_step u_addr_step (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .ctl(step_bus.step)
  );

endmodule : crtc_vert_timing

// ---- logic/crtc_vert_pkg.sv ----
package crtc_vert_pkg;

  // Indexed port addresses (mono and colour aliases)
  localparam logic [15:0] IO_INDEX_MONO = 16'h03B4;
  localparam logic [15:0] IO_DATA_MONO = 16'h03B5;
  localparam logic [15:0] IO_INDEX_COLOR = 16'h03D4;
  localparam logic [15:0] IO_DATA_COLOR = 16'h03D5;

  // Register indices
  localparam logic [7:0] IDX_PROTECT_LAST = 8'h07;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_MAX_SCAN = 8'h09;
  localparam logic [7:0] IDX_VSYNC_START = 8'h10;
  localparam logic [7:0] IDX_VSYNC_END = 8'h11;
  localparam logic [7:0] IDX_VDISP_END = 8'h12;
  localparam logic [7:0] IDX_ROW_OFFSET = 8'h13;
  localparam logic [7:0] IDX_UNDERLINE = 8'h14;
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h17;

  // Field positions: vsync_end_and_protect
  localparam int VSE_PROTECT_BIT = 7;
  localparam int VSE_VINT_EN_BIT = 5;
  localparam int VSE_VINT_CLR_BIT = 4;
  localparam int VSE_END_MSB = 3;
  // Field positions: underline_and_addr_mode
  localparam int UL_DWORD_BIT = 6;
  localparam int UL_QUAD_BIT = 5;
  localparam int UL_LOC_MSB = 4;
  // Field positions: timing_overflow_reg
  localparam int OVF_VSYNC_B9 = 7;
  localparam int OVF_VDISP_B9 = 6;
  localparam int OVF_LINE_CMP_B8 = 4;
  localparam int OVF_VBLANK_B8 = 3;
  localparam int OVF_VSYNC_B8 = 2;
  localparam int OVF_VDISP_B8 = 1;
  // Field positions: max_scan_line_reg, crt_mode_control_reg
  localparam int MSL_VBLANK_B9 = 5;
  localparam int MC_RUN_BIT = 7;
  localparam int MC_BYTE_BIT = 6;
  localparam int MC_DOUBLE_BIT = 3;

  // Writable-bit masks; reserved bits read zero
  localparam logic [7:0] VSE_WMASK = 8'hBF;
  localparam logic [7:0] UL_WMASK = 8'h7F;
  localparam logic [7:0] MC_WMASK = 8'hEF;
  localparam logic [7:0] OVF_UNPROT_MASK = 8'h10;

  // Reset values (undefined in hardware, zero here)
  localparam logic [7:0] REG_RESET = 8'h00;

  // Last count of the character-tick divider for each increment interval
  localparam logic [1:0] STEP_LAST_SINGLE = 2'h0;
  localparam logic [1:0] STEP_LAST_DOUBLE = 2'h1;
  localparam logic [1:0] STEP_LAST_QUAD = 2'h3;

  typedef enum logic [1:0] {MODE_WORD, MODE_BYTE, MODE_DWORD} addr_mode_t;

  function automatic logic [9:0] join10(input logic b9, input logic b8, input logic [7:0] low);
    join10 = {b9, b8, low};
  endfunction : join10

endpackage : crtc_vert_pkg

// ---- logic/addr_step_if.sv ----
`timescale 1ns/1ps
interface addr_step_if;
  import crtc_vert_pkg::*;
  logic dword_sel;
  logic byte_sel;
  logic quad_char_increment;
  logic double_char_increment;
  logic char_tick;
  logic inc_pulse;
  addr_mode_t mode;
  modport ctrl (output dword_sel, output byte_sel, output quad_char_increment,
                output double_char_increment, output char_tick, input inc_pulse, input mode);
  modport step (input dword_sel, input byte_sel, input quad_char_increment,
                input double_char_increment, input char_tick, output inc_pulse, output mode);
endinterface : addr_step_if

// ---- logic/addr_step.sv ----
`timescale 1ns/1ps
module addr_step (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control from register block
  addr_step_if.step ctl
);
  import crtc_vert_pkg::*;

  logic [1:0] tick_cnt_q;
  logic [1:0] tick_cnt_d;
  logic [1:0] last_tick;
  logic at_last;

  // 00 every clock, 01 every 2, 10 every 4, 11 every 2
  assign last_tick = (ctl.quad_char_increment && !ctl.double_char_increment) ? STEP_LAST_QUAD :
                     (ctl.quad_char_increment || ctl.double_char_increment) ? STEP_LAST_DOUBLE :
                     STEP_LAST_SINGLE;
  assign at_last = (tick_cnt_q >= last_tick);
  assign tick_cnt_d = !ctl.char_tick ? tick_cnt_q : (at_last ? 2'h0 : tick_cnt_q + 2'h1);
  assign ctl.inc_pulse = ctl.char_tick && at_last;

  // Doubleword bit wins over the byte/word bit
  assign ctl.mode = ctl.dword_sel ? MODE_DWORD : (ctl.byte_sel ? MODE_BYTE : MODE_WORD);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tick_cnt_q <= 2'h0;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

endmodule : addr_step

// ---- test/crt_monitor.sv ----
`timescale 1ns/1ps
module crt_monitor (
  // Clock
  input wire logic sys_clk,
  // Line pacing and received timing
  input wire logic line_start,
  input wire logic vsync,
  input wire logic vblank,
  // Measured pulse lengths in scan lines
  output logic [9:0] sync_lines,
  output logic [9:0] blank_lines
);
  logic [9:0] sync_run = 10'h000;
  logic [9:0] blank_run = 10'h000;

  // Levels are taken at the next line start, after the previous line settled
  always @(posedge sys_clk)
  begin
    if (line_start)
    begin
      sync_run <= vsync ? sync_run + 10'h001 : 10'h000;
      if (!vsync && sync_run != 10'h000)
        sync_lines <= sync_run;
      blank_run <= vblank ? blank_run + 10'h001 : 10'h000;
      if (!vblank && blank_run != 10'h000)
        blank_lines <= blank_run;
    end
  end
endmodule : crt_monitor

// ---- test/crtc_vert_timing_sva.sv ----
`timescale 1ns/1ps
module crtc_vert_timing_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_color_sel,
  input wire logic [7:0] io_rdata,
  input wire logic io_rd_hit,
  // Timing context
  input wire logic [9:0] scan_line,
  input wire logic line_start,
  input wire logic char_tick,
  input wire logic text_mode,
  // Watched outputs
  input wire logic vsync_out,
  input wire logic vblank_out,
  input wire logic vdisp_active,
  input wire logic underline_hit,
  input wire logic addr_inc,
  input wire logic [9:0] vdisp_end_line,
  input wire logic [9:0] vsync_start_line,
  input wire logic [9:0] vblank_start_line
);
  import crtc_vert_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  wire logic [15:0] idx_port = io_color_sel ? IO_INDEX_COLOR : IO_INDEX_MONO;
  wire logic [15:0] dat_port = io_color_sel ? IO_DATA_COLOR : IO_DATA_MONO;
  wire logic own_port = (io_addr == idx_port) || (io_addr == dat_port);

  sequence s_line;
    line_start;
  endsequence
  sequence s_idle_line;
    !line_start;
  endsequence
  sequence s_rd_other;
    io_rd && !own_port;
  endsequence

  a_foreign_read_quiet: assert property (s_rd_other |=> !io_rd_hit && io_rdata == 8'h00)
    else $error("read on a foreign port answered");
  a_vsync_start_line: assert property ($rose(vsync_out) |-> $past(line_start)
    && $past(scan_line) == $past(vsync_start_line)) else $error("sync rose off its start line");
  a_timing_hold: assert property (s_idle_line |=> $stable(vsync_out) && $stable(vblank_out))
    else $error("sync or blank moved between lines");
  a_vblank_start_line: assert property ($rose(vblank_out) |-> $past(line_start)
    && $past(scan_line) == $past(vblank_start_line)) else $error("blank rose off its start line");
  a_vdisp_compare: assert property (s_line |=> vdisp_active == ($past(scan_line) <= $past(vdisp_end_line)))
    else $error("display active wrong for line");
  a_vdisp_hold: assert property (s_idle_line |=> $stable(vdisp_active))
    else $error("display active moved between lines");
  a_underline_text: assert property (!text_mode |=> !underline_hit)
    else $error("underline outside text mode");
  a_inc_on_tick: assert property (addr_inc |-> char_tick)
    else $error("address step without character tick");
endmodule : crtc_vert_timing_sva

bind crtc_vert_timing crtc_vert_timing_sva sva_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr),
  .io_rd(io_rd), .io_color_sel(io_color_sel), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
  .scan_line(scan_line), .line_start(line_start), .char_tick(char_tick), .text_mode(text_mode),
  .vsync_out(vsync_out), .vblank_out(vblank_out), .vdisp_active(vdisp_active), .underline_hit(underline_hit),
  .addr_inc(addr_inc), .vdisp_end_line(vdisp_end_line), .vsync_start_line(vsync_start_line),
  .vblank_start_line(vblank_start_line));

// ---- test/crtc_vert_timing_test.sv ----
`timescale 1ns/1ps
module crtc_vert_timing_test;
  import crtc_vert_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic io_color_sel = 1'b1;
  logic [9:0] scan_line = 10'h000;
  logic line_start = 1'b0;
  logic [4:0] row_scan = 5'h00;
  logic char_tick = 1'b0;
  logic text_mode = 1'b0;
  logic seq_dword_offset = 1'b0;
  logic [7:0] io_rdata;
  logic io_rd_hit, vsync_out, vblank_out, vdisp_active, underline_hit, addr_inc;
  addr_mode_t addr_mode;
  logic [9:0] row_stride_bytes, vdisp_end_line, vsync_start_line, vblank_start_line, sync_lines, blank_lines;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  // Register rows: index, value written, value read back
  logic [7:0] t_idx [9] = '{8'h07, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h11};
  logic [7:0] t_wd [9] = '{8'hA5, 8'h20, 8'h5A, 8'h81, 8'hFF, 8'h3C, 8'hC3, 8'hFF, 8'hFF};
  logic [7:0] t_rd [9] = '{8'hA5, 8'h20, 8'h5A, 8'h81, 8'h7F, 8'h3C, 8'hC3, 8'hEF, 8'hBF};
  // Mode rows: underline reg, mode control reg, address mode, steps per 8 ticks
  logic [7:0] m_ul [4] = '{8'h00, 8'h00, 8'h20, 8'h60};
  logic [7:0] m_mc [4] = '{8'h80, 8'hC8, 8'h80, 8'hC8};
  addr_mode_t m_mode [4] = '{MODE_WORD, MODE_BYTE, MODE_WORD, MODE_DWORD};
  logic [9:0] m_inc [4] = '{10'h008, 10'h004, 10'h002, 10'h004};

  crtc_vert_timing uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_color_sel(io_color_sel), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
    .scan_line(scan_line), .line_start(line_start), .row_scan(row_scan), .char_tick(char_tick),
    .text_mode(text_mode), .seq_dword_offset(seq_dword_offset), .vsync_out(vsync_out), .vblank_out(vblank_out),
    .vdisp_active(vdisp_active), .underline_hit(underline_hit), .addr_inc(addr_inc), .addr_mode(addr_mode),
    .row_stride_bytes(row_stride_bytes), .vdisp_end_line(vdisp_end_line), .vsync_start_line(vsync_start_line),
    .vblank_start_line(vblank_start_line));

  crt_monitor mon (.sys_clk(sys_clk), .line_start(line_start), .vsync(vsync_out), .vblank(vblank_out),
    .sync_lines(sync_lines), .blank_lines(blank_lines));

  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %0t %s got %b expected %b", $time, m, got, exp);
    end
  endtask : chk_bit

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  function automatic logic [15:0] dport();
    return io_color_sel ? IO_DATA_COLOR : IO_DATA_MONO;
  endfunction : dport

  // Leaves the write strobe high so a data write can follow without a gap
  task automatic put_index(input logic [7:0] idx);
    io_addr = io_color_sel ? IO_INDEX_COLOR : IO_INDEX_MONO;
    io_wr = 1'b1;
    io_wdata = idx;
    tick();
  endtask : put_index

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    put_index(idx);
    io_addr = dport();
    io_wdata = d;
    tick();
    io_wr = 1'b0;
    tick();
  endtask : wr

  task automatic rd_port(input logic [15:0] a, input logic [7:0] e, input logic hit);
    io_addr = a;
    io_rd = 1'b1;
    tick();
    io_rd = 1'b0;
    chk({2'b00, io_rdata}, {2'b00, e}, "read data");
    chk_bit(io_rd_hit, hit, "read hit");
  endtask : rd_port

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic hit);
    put_index(idx);
    io_wr = 1'b0;
    rd_port(dport(), e, hit);
  endtask : rd

  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    wr(IDX_MAX_SCAN, 8'h20);
    for (int i = 0; i < 9; i++)
    begin
      wr(t_idx[i], t_wd[i]);
      rd(t_idx[i], t_rd[i], 1'b1);
    end
    chk(vdisp_end_line, 10'h05A, "display end");
    chk(vsync_start_line, 10'h320, "sync start");
    chk(vblank_start_line, 10'h23C, "blank start");
    tick();
    tick();
    chk(row_stride_bytes, 10'h102, "stride words");
    seq_dword_offset = 1'b1;
    tick();
    tick();
    chk(row_stride_bytes, 10'h204, "stride dwords");
    // Protection is on now: only the line-compare bit of the overflow register moves
    wr(IDX_OVERFLOW, 8'h5A);
    rd(IDX_OVERFLOW, 8'hB5, 1'b1);
    rd(8'h20, 8'h00, 1'b0);
    tick();
    rd_port(IO_DATA_MONO, 8'h00, 1'b0);
    io_color_sel = 1'b0;
    wr(IDX_VSYNC_END, 8'h03);
    rd(IDX_VSYNC_END, 8'h03, 1'b1);
    io_color_sel = 1'b1;
    wr(IDX_OVERFLOW, 8'h00);
    rd(IDX_OVERFLOW, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_UNDERLINE, m_ul[i]);
      wr(IDX_MODE_CTRL, m_mc[i]);
      chk({8'h00, addr_mode}, {8'h00, m_mode[i]}, "address mode");
      n = 0;
      for (int k = 0; k < 12; k++)
      begin
        char_tick = 1'b1;
        #1;
        if (k >= 4 && addr_inc === 1'b1)
          n++;
        tick();
        char_tick = 1'b0;
        tick();
      end
      chk(n[9:0], m_inc[i], "steps");
    end
    wr(IDX_UNDERLINE, 8'h05);
    for (int i = 0; i < 3; i++)
    begin
      text_mode = (i != 1);
      row_scan = (i == 2) ? 5'h04 : 5'h05;
      tick();
      tick();
      chk_bit(underline_hit, i == 0, "underline");
    end
    wr(IDX_MAX_SCAN, 8'h00);
    wr(IDX_VSYNC_START, 8'h20);
    wr(IDX_VBLANK_START, 8'h18);
    wr(IDX_VBLANK_END, 8'h1D);
    wr(IDX_VDISP_END, 8'h10);
    wr(IDX_MODE_CTRL, 8'h80);
    for (int ln = 0; ln < 48; ln++)
    begin
      scan_line = ln[9:0];
      line_start = 1'b1;
      tick();
      line_start = 1'b0;
      tick();
      tick();
      chk_bit(vdisp_active, ln <= 16, "display active");
    end
    chk(sync_lines, 10'h003, "sync length");
    chk(blank_lines, 10'h005, "blank length");
    // Controller reset bit low: the sync start line passes with sync held off
    wr(IDX_MODE_CTRL, 8'h00);
    scan_line = 10'h020;
    line_start = 1'b1;
    tick();
    line_start = 1'b0;
    tick();
    chk_bit(vsync_out, 1'b0, "sync while stopped");
    sys_rst = 1'b1;
    tick();
    tick();
    sys_rst = 1'b0;
    rd(IDX_VSYNC_END, 8'h00, 1'b1);
    wr(IDX_OVERFLOW, 8'h80);
    rd(IDX_OVERFLOW, 8'h80, 1'b1);
    tick();
    rd_port(IO_INDEX_COLOR, IDX_OVERFLOW, 1'b1);
    results();
  end
endmodule : crtc_vert_timing_test
